// [rtl/ogd_decoder.sv]
// top of the 8..e group instruction decoder: accepts a word,
// collects appended address-mode words, presents one decode
// assumes in_* and aw_* come from logic on ref_clk
//
// How it works
// - leading b, second digit 0-7: no execute, soft exception trap
// - leading d, second digit 8-f: illegal operation, program check
// - register-storage direction bit: 0 storage to register, 1 reverse
// - displacement-with-base format decodes an indirect bit for address fetch
// - 10101 format yields two bases, two modes, function, then appended words
// - functions 0-7 storage to register, 8-b,e,f register to storage
`timescale 1ns/10ps
`default_nettype none

module ogd_decoder
    import ogd_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // instruction word in
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [15:0] in_word,
    // appended address-mode words in
    input wire logic aw_valid,
    output logic aw_ready,
    input wire logic [15:0] aw_word,
    // decode out
    output logic out_valid,
    output ogd_dec_t out_dec,
    output logic [15:0] out_word1,
    output logic [15:0] out_word2
);
    typedef enum logic [1:0] {ST_IDLE, ST_FETCH1, ST_FETCH2, ST_DONE} ogd_state_t;

    ogd_state_t state_ff;
    ogd_state_t nxt_state;
    ogd_dec_t dec_ff;
    ogd_dec_t nxt_dec;
    logic [15:0] word1_ff;
    logic [15:0] word2_ff;
    logic accept;
    logic take_aw;

    ogd_field_decode u_fields (
        .word(in_word),
        .dec(nxt_dec)
    );

    assign in_ready = (state_ff == ST_IDLE);
    assign aw_ready = (state_ff == ST_FETCH1) || (state_ff == ST_FETCH2);
    assign out_valid = (state_ff == ST_DONE);
    assign accept = in_valid && in_ready;
    assign take_aw = aw_valid && aw_ready;
    assign out_dec = dec_ff;
    assign out_word1 = word1_ff;
    assign out_word2 = word2_ff;

    // sequencing
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (accept) begin
                    if (nxt_dec.need_w1) begin
                        nxt_state = ST_FETCH1;
                    end else if (nxt_dec.need_w2) begin
                        nxt_state = ST_FETCH2;
                    end else begin
                        nxt_state = ST_DONE;
                    end
                end
            end
            ST_FETCH1: begin
                if (aw_valid) begin
                    nxt_state = dec_ff.need_w2 ? ST_FETCH2 : ST_DONE;
                end
            end
            ST_FETCH2: begin
                if (aw_valid) begin
                    nxt_state = ST_DONE;
                end
            end
            ST_DONE: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // decode capture
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            dec_ff <= '0;
        end else if (accept) begin
            dec_ff <= nxt_dec;
        end
    end

    // appended word capture
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            word1_ff <= WORD_RST;
            word2_ff <= WORD_RST;
        end else if (accept) begin
            word1_ff <= WORD_RST;
            word2_ff <= WORD_RST;
        end else if (take_aw && state_ff == ST_FETCH1) begin
            word1_ff <= aw_word;
        end else if (take_aw) begin
            word2_ff <= aw_word;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    a_soft_trap_raise: assert property (
        accept && in_word[15:12] == DIG_TRAP && !in_word[HALF_BIT]
        |=> out_valid && out_dec.soft_trap && out_dec.op == OGD_OP_NONE)
        else $error("lower b did not trap");

    a_prog_check_raise: assert property (
        accept && in_word[15:12] == DIG_RS_D && in_word[HALF_BIT]
        |=> out_valid && out_dec.prog_check && !out_dec.need_w1)
        else $error("upper d did not raise program check");

    a_rs_direction: assert property (
        accept && in_word[15:13] == 3'b110 && !(in_word[15:12] == DIG_RS_D && in_word[HALF_BIT])
        |=> out_dec.dir == $past(in_word[DIR_BIT]))
        else $error("direction bit wrong");

    a_indirect_bit: assert property (
        accept && in_word[15:12] == DIG_DISP && !in_word[HALF_BIT]
        |=> out_dec.indirect == $past(in_word[IND_A_BIT]) && state_ff == ST_FETCH1)
        else $error("indirect bit or displacement fetch wrong");

    a_ss_fields: assert property (
        accept && in_word[15:12] == DIG_DISP && in_word[HALF_BIT]
        |=> out_dec.base1 == $past(in_word[10:9]) && out_dec.base2 == $past(in_word[8:7])
            && out_dec.mode1 == $past(in_word[6:5]) && out_dec.mode2 == $past(in_word[4:3]))
        else $error("storage-to-storage fields wrong");

    a_ss_two_words: assert property (
        state_ff == ST_FETCH1 && dec_ff.need_w2 && aw_valid
        ##1 aw_valid |=> out_valid && out_word2 == $past(aw_word) && out_word1 == $past(aw_word, 2))
        else $error("appended words out of order");

    a_func_order: assert property (
        accept && in_word[15:12] == DIG_RS_BW && !in_word[HALF_BIT]
            && in_word[3:0] == FN_MOVE_CLEAR
        |=> out_dec.op == OGD_OP_MOVE_CLEAR && out_dec.size == OGD_SZ_BYTE && !out_dec.dir)
        else $error("function 5 not move then clear");

    a_func_reverse: assert property (
        accept && in_word[15:12] == DIG_RS_BW && in_word[HALF_BIT] && in_word[3:0] == 4'hf
        |=> out_dec.op == OGD_OP_SUB && out_dec.size == OGD_SZ_WORD && out_dec.dir)
        else $error("function f not register-to-storage subtract");

    a_gap_invalid: assert property (
        accept && in_word[15:13] == 3'b110 && in_word[3:1] == 3'h6
        |=> out_valid && out_dec.prog_check)
        else $error("function c or d accepted");

    a_done_pulse: assert property (
        out_valid |=> !out_valid && in_ready)
        else $error("decode valid longer than one cycle");

    a_trap_no_fetch: assert property (
        accept && in_word[15:12] == DIG_TRAP
        |=> out_valid && !out_dec.need_w1 && !out_dec.need_w2)
        else $error("trap group fetched an appended word");

    a_double_store: assert property (
        accept && in_word[15:12] == DIG_RS_D && !in_word[HALF_BIT] && in_word[3:0] == 4'he
        |=> out_dec.op == OGD_OP_ADD && out_dec.size == OGD_SZ_DOUBLE && out_dec.dir)
        else $error("function e not register-to-storage add");

    a_fetch_needed: assert property (
        accept && in_word[15:12] == DIG_RS_BW && in_word[4 + AM_DISP_BIT]
            && in_word[3:1] != 3'h6
        |=> aw_ready && !out_valid && !in_ready)
        else $error("appended word not requested");

    a_ss_mode_fetch: assert property (
        accept && in_word[15:12] == DIG_DISP && in_word[HALF_BIT]
        |=> out_dec.need_w1 == $past(in_word[6]) && out_dec.need_w2 == $past(in_word[4]))
        else $error("storage-to-storage fetch needs wrong");

    a_word1_lands: assert property (
        take_aw && state_ff == ST_FETCH1 |=> out_word1 == $past(aw_word))
        else $error("first appended word not captured");

    a_word2_lands: assert property (
        take_aw && state_ff == ST_FETCH2 |=> out_word2 == $past(aw_word))
        else $error("second appended word not captured");

    a_fetch_wait: assert property (
        aw_ready && !aw_valid |=> aw_ready && !out_valid)
        else $error("fetch abandoned without a word");

    a_refused_word: assert property (
        in_valid && !in_ready |=> $stable(out_dec))
        else $error("decode changed while busy");

    c_indirect_fetch: cover property (out_valid && out_dec.indirect);
    c_soft_trap: cover property (out_valid && out_dec.soft_trap);
    c_two_words: cover property (out_valid && out_dec.need_w1 && out_dec.need_w2);
    c_program_check: cover property (out_valid && out_dec.prog_check);
    c_stall_fetch: cover property (aw_ready && !aw_valid ##1 aw_ready && aw_valid);
endmodule : ogd_decoder

`default_nettype wire

// [rtl/ogd_pkg.sv]
// package and field decoder for the 8..e instruction group
// assumes a 16-bit word, bit 0 of the word as the msb (word[15])
`timescale 1ns/10ps
`default_nettype none

package ogd_pkg;
    // leading hex digits
    localparam logic [3:0] DIG_SS_BW = 4'h8;
    localparam logic [3:0] DIG_SS_DJ = 4'h9;
    localparam logic [3:0] DIG_DISP = 4'ha;
    localparam logic [3:0] DIG_TRAP = 4'hb;
    localparam logic [3:0] DIG_RS_BW = 4'hc;
    localparam logic [3:0] DIG_RS_D = 4'hd;
    localparam logic [3:0] DIG_SHORT = 4'he;
    // field positions
    localparam int HALF_BIT = 11;
    localparam int DIR_BIT = 3;
    localparam int IND_A_BIT = 5;
    localparam int IND_E_BIT = 7;
    localparam int AM_DISP_BIT = 1;
    // function codes
    localparam logic [3:0] FN_MOVE = 4'h0;
    localparam logic [3:0] FN_OR = 4'h1;
    localparam logic [3:0] FN_CLEAR_BITS = 4'h2;
    localparam logic [3:0] FN_XOR = 4'h3;
    localparam logic [3:0] FN_COMPARE = 4'h4;
    localparam logic [3:0] FN_MOVE_CLEAR = 4'h5;
    localparam logic [3:0] FN_ADD = 4'h6;
    localparam logic [3:0] FN_SUB = 4'h7;
    localparam logic [3:0] FN_GAP_LO = 4'hc;
    localparam logic [3:0] FN_GAP_HI = 4'hd;
    // reset values
    localparam logic [15:0] WORD_RST = 16'h0000;

    typedef enum logic [3:0] {
        OGD_OP_NONE, OGD_OP_MOVE, OGD_OP_OR, OGD_OP_CLEAR_BITS, OGD_OP_XOR,
        OGD_OP_COMPARE, OGD_OP_MOVE_CLEAR, OGD_OP_ADD, OGD_OP_SUB,
        OGD_OP_JUMP_LINK, OGD_OP_COUNT_JUMP, OGD_OP_DISP_GROUP,
        OGD_OP_SS_GROUP, OGD_OP_MOVE_SHORT, OGD_OP_STACK_GROUP
    } ogd_op_t;

    typedef enum logic [1:0] {OGD_SZ_NONE, OGD_SZ_BYTE, OGD_SZ_WORD, OGD_SZ_DOUBLE} ogd_size_t;

    typedef struct packed {
        ogd_op_t op;
        ogd_size_t size;
        logic [4:0] func;
        logic dir;
        logic [2:0] reg_sel;
        logic [1:0] base1;
        logic [1:0] base2;
        logic [1:0] mode1;
        logic [1:0] mode2;
        logic indirect;
        logic [6:0] short_disp;
        logic need_w1;
        logic need_w2;
        logic soft_trap;
        logic prog_check;
        logic foreign;
    } ogd_dec_t;
endpackage : ogd_pkg

module ogd_field_decode
    import ogd_pkg::*;
(
    // instruction in
    input wire logic [15:0] word,
    // decoded fields out
    output ogd_dec_t dec
);
    logic [3:0] dig;
    logic upper;
    logic [3:0] fn;
    assign dig = word[15:12];
    assign upper = word[HALF_BIT];
    assign fn = word[3:0];

    always_comb begin
        dec = '0;
        dec.reg_sel = word[10:8];
        dec.func = {1'b0, fn};
        unique case (dig)
            DIG_SS_BW, DIG_SS_DJ: begin
                if (dig == DIG_SS_DJ && upper) begin
                    dec.op = OGD_OP_JUMP_LINK;
                end else begin
                    dec.size = (dig == DIG_SS_DJ) ? OGD_SZ_DOUBLE
                             : (upper ? OGD_SZ_WORD : OGD_SZ_BYTE);
                    dec.func = {3'b000, word[1:0]};
                    unique case (word[1:0])
                        2'h0: dec.op = OGD_OP_MOVE;
                        2'h1: dec.op = OGD_OP_OR;
                        2'h2: dec.op = OGD_OP_CLEAR_BITS;
                        2'h3: dec.op = OGD_OP_COMPARE;
                    endcase
                    dec.base1 = word[10:9];
                    dec.base2 = word[8:7];
                    dec.mode1 = word[6:5];
                    dec.mode2 = word[4:3];
                    dec.need_w1 = word[6];
                    dec.need_w2 = word[4];
                end
            end
            DIG_DISP: begin
                if (upper) begin
                    dec.op = OGD_OP_SS_GROUP;
                    dec.base1 = word[10:9];
                    dec.base2 = word[8:7];
                    dec.mode1 = word[6:5];
                    dec.mode2 = word[4:3];
                    dec.func = {2'b00, word[2:0]};
                    dec.need_w1 = word[6];
                    dec.need_w2 = word[4];
                end else begin
                    dec.op = OGD_OP_DISP_GROUP;
                    dec.base1 = word[7:6];
                    dec.indirect = word[IND_A_BIT];
                    dec.func = word[4:0];
                    dec.need_w1 = 1'b1;
                end
            end
            DIG_TRAP: begin
                if (upper) begin
                    dec.op = OGD_OP_COUNT_JUMP;
                end else begin
                    dec.soft_trap = 1'b1;
                end
            end
            DIG_RS_BW, DIG_RS_D: begin
                if (dig == DIG_RS_D && upper) begin
                    dec.prog_check = 1'b1;
                end else begin
                    dec.size = (dig == DIG_RS_D) ? OGD_SZ_DOUBLE
                             : (upper ? OGD_SZ_WORD : OGD_SZ_BYTE);
                    dec.base1 = word[7:6];
                    dec.mode1 = word[5:4];
                    dec.need_w1 = word[4 + AM_DISP_BIT];
                    dec.dir = fn[DIR_BIT];
                    unique case ({1'b0, fn[2:0]})
                        FN_MOVE: dec.op = OGD_OP_MOVE;
                        FN_OR: dec.op = OGD_OP_OR;
                        FN_CLEAR_BITS: dec.op = OGD_OP_CLEAR_BITS;
                        FN_XOR: dec.op = OGD_OP_XOR;
                        FN_COMPARE: dec.op = OGD_OP_COMPARE;
                        FN_MOVE_CLEAR: dec.op = OGD_OP_MOVE_CLEAR;
                        FN_ADD: dec.op = OGD_OP_ADD;
                        default: dec.op = OGD_OP_SUB;
                    endcase
                    if (fn == FN_GAP_LO || fn == FN_GAP_HI) begin
                        dec.op = OGD_OP_NONE;
                        dec.need_w1 = 1'b0;
                        dec.prog_check = 1'b1;
                    end
                end
            end
            DIG_SHORT: begin
                if (upper) begin
                    dec.op = OGD_OP_STACK_GROUP;
                    dec.base1 = word[7:6];
                    dec.mode1 = word[5:4];
                    dec.need_w1 = word[4 + AM_DISP_BIT];
                    if (fn >= FN_GAP_LO) begin
                        dec.op = OGD_OP_NONE;
                        dec.need_w1 = 1'b0;
                        dec.prog_check = 1'b1;
                    end
                end else begin
                    dec.op = OGD_OP_MOVE_SHORT;
                    dec.indirect = word[IND_E_BIT];
                    dec.short_disp = word[6:0];
                end
            end
            default: dec.foreign = 1'b1;
        endcase
    end
endmodule : ogd_field_decode

`default_nettype wire

// [test/ogd_decoder_tb_top.sv]
// self-checking bench for the 8..e group decoder with a reference model
// assumes ogd_fetch_model numbers appended words from zero after reset
`timescale 1ns/10ps
`default_nettype none

module ogd_decoder_tb_top
    import ogd_pkg::*;
;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic in_valid = 1'b0;
    logic [15:0] in_word = 16'h0000;
    logic in_ready, aw_valid, aw_ready, out_valid;
    logic [15:0] aw_word, out_word1, out_word2;
    ogd_dec_t out_dec;
    int err_count = 0;
    int tests_run = 0;
    int wk = 0;
    int kind;
    logic [31:0] seed = 32'd90567;
    ogd_op_t e_op;
    ogd_size_t e_sz;
    logic e_dir, e_tr, e_pc, e_n1, e_n2;
    logic [4:0] e_fn;
    logic [15:0] dir_w [9] = '{16'hc015, 16'ha850, 16'hb3ff, 16'hd8a5, 16'hc00c,
        16'hc8dd, 16'ha020, 16'hc82e, 16'hd7a9};

    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    ogd_decoder i_ogd_decoder (.ref_clk(ref_clk), .srst(srst), .in_valid(in_valid),
        .in_ready(in_ready), .in_word(in_word), .aw_valid(aw_valid), .aw_ready(aw_ready),
        .aw_word(aw_word), .out_valid(out_valid), .out_dec(out_dec),
        .out_word1(out_word1), .out_word2(out_word2));

    ogd_fetch_model i_ogd_fetch_model (.ref_clk(ref_clk), .srst(srst),
        .aw_ready(aw_ready), .aw_valid(aw_valid), .aw_word(aw_word));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    function automatic ogd_op_t fn_op(input logic [3:0] f);
        case (f)
            4'h0, 4'h8: return OGD_OP_MOVE;
            4'h1, 4'h9: return OGD_OP_OR;
            4'h2, 4'ha: return OGD_OP_CLEAR_BITS;
            4'h3, 4'hb: return OGD_OP_XOR;
            4'h4: return OGD_OP_COMPARE;
            4'h5: return OGD_OP_MOVE_CLEAR;
            4'h6, 4'he: return OGD_OP_ADD;
            4'h7, 4'hf: return OGD_OP_SUB;
            default: return OGD_OP_NONE;
        endcase
    endfunction : fn_op

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic model(input logic [15:0] w);
        {e_tr, e_pc, e_n1, e_n2, e_dir, kind} = 0;
        e_op = OGD_OP_NONE;
        e_sz = OGD_SZ_NONE;
        e_fn = {1'b0, w[3:0]};
        if (w[15:12] < 4'h8 || w[15:12] == 4'hf) begin
            kind = 4;
        end else if (w[15:12] == 4'hb) begin
            e_tr = !w[11];
            e_op = w[11] ? OGD_OP_COUNT_JUMP : OGD_OP_NONE;
        end else if (w[15:12] == 4'h9 && w[11]) begin
            e_op = OGD_OP_JUMP_LINK;
        end else if (w[15:12] == 4'h8 || w[15:12] == 4'h9) begin
            e_op = (w[1:0] == 2'h3) ? OGD_OP_COMPARE : fn_op({2'b00, w[1:0]});
            e_sz = (w[15:12] == 4'h9) ? OGD_SZ_DOUBLE : (w[11] ? OGD_SZ_WORD : OGD_SZ_BYTE);
            e_fn = {3'b000, w[1:0]};
            e_n1 = w[6];
            e_n2 = w[4];
            kind = 2;
        end else if (w[15:12] == 4'hd && w[11]) begin
            e_pc = 1'b1;
        end else if (w[15:12] == 4'hc || w[15:12] == 4'hd) begin
            e_pc = (w[3:0] == 4'hc || w[3:0] == 4'hd);
            e_op = fn_op(w[3:0]);
            e_sz = (w[15:12] == 4'hd) ? OGD_SZ_DOUBLE : (w[11] ? OGD_SZ_WORD : OGD_SZ_BYTE);
            e_dir = w[3];
            e_n1 = w[5] && !e_pc;
            kind = 1;
        end else if (w[15:12] == 4'ha) begin
            e_op = w[11] ? OGD_OP_SS_GROUP : OGD_OP_DISP_GROUP;
            e_fn = w[11] ? {2'b00, w[2:0]} : w[4:0];
            e_n1 = w[11] ? w[6] : 1'b1;
            e_n2 = w[11] && w[4];
            kind = w[11] ? 2 : 3;
        end else if (w[11]) begin
            e_pc = (w[3:0] >= 4'hc);
            e_op = e_pc ? OGD_OP_NONE : OGD_OP_STACK_GROUP;
            e_n1 = w[5] && !e_pc;
            kind = 1;
        end else begin
            e_op = OGD_OP_MOVE_SHORT;
            kind = 5;
        end
    endtask : model

    task automatic send(input logic [15:0] w);
        int n;
        logic [15:0] x1, x2;
        model(w);
        x1 = 16'h0000;
        x2 = 16'h0000;
        if (e_n1) begin
            x1 = {8'ha0, 8'(wk)};
            wk++;
        end
        if (e_n2) begin
            x2 = {8'ha0, 8'(wk)};
            wk++;
        end
        @(negedge ref_clk);
        in_valid <= 1'b1;
        in_word <= w;
        n = 0;
        while (in_ready !== 1'b1 && n < 50) begin
            @(negedge ref_clk);
            n++;
        end
        @(negedge ref_clk);
        in_valid <= 1'b0;
        in_word <= ~w;
        while (out_valid !== 1'b1 && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        chk("out_valid", 16'(out_valid), 16'h0001);
        chk("in_ready", 16'(in_ready), 16'h0000);
        chk("aw_ready", 16'(aw_ready), 16'h0000);
        chk("soft_trap", 16'(out_dec.soft_trap), 16'(e_tr));
        chk("prog_check", 16'(out_dec.prog_check), 16'(e_pc));
        chk("need_w1", 16'(out_dec.need_w1), 16'(e_n1));
        chk("need_w2", 16'(out_dec.need_w2), 16'(e_n2));
        chk("out_word1", out_word1, x1);
        chk("out_word2", out_word2, x2);
        chk("op", 16'(out_dec.op), 16'(e_op));
        chk("func", 16'(out_dec.func), 16'(e_fn));
        chk("reg_sel", 16'(out_dec.reg_sel), 16'(w[10:8]));
        chk("foreign", 16'(out_dec.foreign), 16'(kind == 4));
        chk("indirect", 16'(out_dec.indirect), 16'(kind == 3 ? w[5] : kind == 5 && w[7]));
        chk("short_disp", 16'(out_dec.short_disp), 16'(kind == 5 ? w[6:0] : 7'h00));
        if (kind == 1) chk("dir", 16'(out_dec.dir), 16'(e_dir));
        if (kind == 1 || kind == 2) chk("size", 16'(out_dec.size), 16'(e_sz));
        if (kind == 1) chk("rs_fields", 16'({out_dec.base1, out_dec.mode1}), 16'(w[7:4]));
        if (kind == 2) chk("ss_fields", 16'({out_dec.base1, out_dec.base2, out_dec.mode1,
            out_dec.mode2}), 16'(w[10:3]));
        if (kind == 3) chk("disp_base", 16'(out_dec.base1), 16'(w[7:6]));
    endtask : send

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        close_out();
    end

    initial begin
        repeat (16) @(posedge ref_clk);
        @(negedge ref_clk);
        srst <= 1'b0;
        foreach (dir_w[i]) send(dir_w[i]);
        @(negedge ref_clk);
        srst <= 1'b1;
        repeat (2) @(negedge ref_clk);
        chk("rst_in_ready", 16'(in_ready), 16'h0001);
        chk("rst_aw_ready", 16'(aw_ready), 16'h0000);
        chk("rst_out_valid", 16'(out_valid), 16'h0000);
        chk("rst_out_dec", 16'(out_dec != '0), 16'h0000);
        chk("rst_words", out_word1 | out_word2, 16'h0000);
        srst <= 1'b0;
        wk = 0;
        $display("directed test done");
        for (int i = 0; i < 300; i++) begin
            seed = xs(seed);
            send({seed[20] ? seed[15:12] : 4'h8 + {1'b0, seed[14:12]}, seed[11:0]});
        end
        $display("random test done");
        close_out();
    end
endmodule : ogd_decoder_tb_top

`default_nettype wire

// [test/ogd_fetch_model.sv]
// operand fetch model: answers appended address-mode word requests
// assumes aw_ready is the request; words are 8'ha0 then a running count
`timescale 1ns/10ps
`default_nettype none

module ogd_fetch_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // fetch handshake
    input wire logic aw_ready,
    output logic aw_valid,
    output logic [15:0] aw_word
);
    logic took;
    logic [7:0] cnt;
    logic [7:0] lf;

    initial begin
        aw_valid = 1'b0;
        aw_word = 16'h0000;
        took = 1'b0;
        cnt = 8'h00;
        lf = 8'h5b;
    end

    always @(posedge ref_clk) begin
        took <= aw_valid && aw_ready;
    end

    // random stall, word held until taken, changing pattern when idle
    always @(negedge ref_clk) begin
        lf <= {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
        if (srst) begin
            aw_valid <= 1'b0;
            cnt <= 8'h00;
        end else if (!(aw_valid && !took)) begin
            cnt <= cnt + 8'(took);
            aw_valid <= aw_ready && lf[0];
            aw_word <= (aw_ready && lf[0]) ? {8'ha0, cnt + 8'(took)} : ~aw_word;
        end
    end
endmodule : ogd_fetch_model

`default_nettype wire
